// [lscr_map.svh]
// Purpose: Offsets, fields, reset values and timing for the linked repeater
// Assumes: 32-bit APB, byte-wide channel streams
// Notes: Included by the repeater and tb_top
`ifndef LSCR_MAP_SVH
`define LSCR_MAP_SVH
`define LSCR_CFG_OFF 12'h000
`define LSCR_HDR_OFF 12'h004
`define LSCR_GATE_OFF 12'h008
`define LSCR_STAT_OFF 12'h00c
`define LSCR_P1_LSB 0
`define LSCR_R1_BIT 4
`define LSCR_P2_LSB 8
`define LSCR_R2_BIT 12
`define LSCR_STN_LSB 16
`define LSCR_ATT_BIT 24
`define LSCR_CSIDE_BIT 25
`define LSCR_AREF_BIT 26
`define LSCR_OVR_LSB 1
`define LSCR_CFG_RST 32'h0000_0000
`define LSCR_HDR_RST 8'h00
`define LSCR_GATE_RST 16'h0000
`define LSCR_P_LINK 4'h8
`define LSCR_P_NP 4'h6
`define LSCR_P_BI 4'h7
`define LSCR_P_F2 4'h2
`define LSCR_P_F5 4'h5
`define LSCR_HL_F134 4'hd
`define LSCR_HL_F2 4'hf
`define LSCR_HL_F5 4'ha
`define LSCR_ENQ 8'h05
`define LSCR_STX 8'h02
`define LSCR_ACK 8'h06
`define LSCR_NAK 8'h15
`define LSCR_DLE 8'h10
`define LSCR_CLK_NS 10
`define LSCR_GAP_NS 20000
`define LSCR_GAP_CYC (`LSCR_GAP_NS / `LSCR_CLK_NS)
`endif

// [lscr_pkg.sv]
// Purpose: Types for the linked repeater
// Assumes: Nothing
// Notes: Constants live in lscr_map.svh
package lscr_pkg;
    typedef enum logic [3:0] {
        E_IDLE, E_HOLD, E_HDR, E_SST, E_SSTN, E_CHK, E_LSTN, E_LOCAL, E_FWD
    } lscr_eng_e;
    typedef enum logic [1:0] {R_IDLE, R_HDR, R_BYTE} lscr_rsp_e;
endpackage

// [lscr_repeater.sv]
// Purpose: Linked two-channel serial repeater with routing header handling
// Assumes: Byte streams from/to the channel UARTs on pclk
// Notes: Message end is an idle gap on the source channel
//
// Design decisions made here: register access over APB and the register offsets.
`include "lscr_map.svh"

// Function
// R1: Software links: first code 8 with role bit clear, second role set, code 0-6.
// R2: Both channels share framing; rate matches attached equipment.
// R3: No linking without equipment, with bidirectional, predefined or modem use.
// R4: Linked channels both run the second channel's protocol.
// R5: Every received character is repeated on the opposite channel.
// R6: In non-procedure mode stations arbitrate received data themselves.
// R7: Execute a command only when its station byte equals ours.
// R8: Command frames to other stations carry a routing header.
// R9: Computer-side station prepends header to commands for other stations.
// R10: Computer-side station strips header from responses of other stations.
// R11: Header still sent in many-to-many arrangements.
// R12: Addressed station responds with header on the arrival channel.
// R13: ASCII header precedes start code; 13 chars, 15 for format 2.
// R14: Binary format 5 header is 10 bytes before DLE.
// R15: Character time in linked mode equals the gate-off time.
// R16: Non-procedure or bidirectional reception raises a host interrupt.
// R17: First channel uses interrupt number 0, second number 1.
// R18: Host maps both interrupts to consecutive vectors 50 to 255.
// R19: Auto-refresh copies status words to host storage unasked.
// R20: Station number is 0 to 31.
// R21: Forwarding keeps order and starts per character.
module lscr_repeater #(
    parameter int GAP_CYC = `LSCR_GAP_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel streams, bit/byte 0 is first_channel
    input wire logic [1:0] rx_valid,
    input wire logic [15:0] rx_data,
    output logic [1:0] tx_valid,
    output logic [15:0] tx_data,
    input wire logic [1:0] tx_ready,
    // Receive interrupts
    output logic [1:0] rx_irq,
    // Local command executor
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    output logic resp_ready,
    // Auto-refresh
    output logic aref_valid,
    output logic [31:0] aref_data
);
    import lscr_pkg::*;

    function automatic logic is_start(input logic [3:0] p, input logic [7:0] b);
        if (p == `LSCR_P_F5)
            return b == `LSCR_DLE;
        return b == `LSCR_ENQ || b == `LSCR_STX || b == `LSCR_ACK || b == `LSCR_NAK;
    endfunction

    function automatic logic [3:0] hdr_len(input logic [3:0] p);
        if (p == `LSCR_P_F2)
            return `LSCR_HL_F2;
        if (p == `LSCR_P_F5)
            return `LSCR_HL_F5;
        return `LSCR_HL_F134;
    endfunction

    logic [31:0] cfg_ff, nxt_cfg;
    logic [7:0] hdr_ff, nxt_hdr;
    logic [15:0] gate_ff, nxt_gate;
    logic [1:0] ovr_ff, nxt_ovr;
    logic rch_ff, nxt_rch;
    logic [15:0] last_ff, nxt_last;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [1:0] irq_ff, nxt_irq;
    logic cmdv_ff, nxt_cmdv;
    logic [7:0] cmdd_ff, nxt_cmdd;
    logic arefv_ff, nxt_arefv;
    logic [31:0] arefd_ff, nxt_arefd;
    lscr_rsp_e rst_ff, nxt_rst;
    logic [7:0] rb_ff, nxt_rb;
    logic [3:0] rcnt_ff, nxt_rcnt;
    logic rrdy_ff, nxt_rrdy;

    wire [1:0] emit_v, loc_v, eovr, sovr, free, enter;
    wire [15:0] emit_b, loc_b;
    logic [3:0] p1, p2;
    logic [4:0] stn;
    logic linked, att, cside, hit, rv, rfree, rneed;
    logic [7:0] rbo;
    logic [31:0] stat_w, rd_w;
    wire [7:0] rx0_b = rx_data[7:0];

    always_comb begin
        p1 = cfg_ff[`LSCR_P1_LSB +: 4];
        p2 = cfg_ff[`LSCR_P2_LSB +: 4];
        // R20: five-bit station
        stn = cfg_ff[`LSCR_STN_LSB +: 5];
        att = cfg_ff[`LSCR_ATT_BIT];
        cside = cfg_ff[`LSCR_CSIDE_BIT];
        // R1: linked decode
        linked = p1 == `LSCR_P_LINK && !cfg_ff[`LSCR_R1_BIT] && cfg_ff[`LSCR_R2_BIT]
            && p2 <= `LSCR_P_NP;
        stat_w = {8'h00, last_ff, 4'h0, rch_ff, ovr_ff, linked};
    end

    // One engine per source channel, repeating onto the other channel
    for (genvar s = 0; s < 2; s++) begin : eng
        lscr_eng_e st_ff, nst;
        logic [7:0] hold_ff, nhold, stn_ff, nstn, eb, lb;
        logic [3:0] cnt_ff, ncnt, eff;
        logic [11:0] gap_ff, ngap;
        logic ftoo_ff, nftoo, ev, lv, ov, cmdp, ins, strip, tmo, own, st;
        wire rxv = rx_valid[s];
        wire [7:0] rxb = rx_data[s*8 +: 8];
        always_comb begin
            // R4: linked channels follow the second protocol
            eff = (linked || s == 1) ? p2 : p1;
            cmdp = eff >= 4'h1 && eff <= `LSCR_P_F5;
            ins = cmdp && att && cside == 1'(s);
            strip = cmdp && att && cside != 1'(s);
            st = is_start(eff, rxb);
            own = rxb == {3'h0, stn};
            tmo = gap_ff == 12'(GAP_CYC);
            nst = st_ff;
            nhold = hold_ff;
            nstn = stn_ff;
            ncnt = cnt_ff;
            nftoo = ftoo_ff;
            ngap = rxv ? 12'h000 : (tmo ? gap_ff : gap_ff + 12'h001);
            ev = 1'b0;
            eb = rxb;
            lv = 1'b0;
            lb = rxb;
            ov = 1'b0;
            unique case (st_ff)
                E_IDLE: if (rxv && linked) begin
                    // R5: repeat each character at once
                    if (!cmdp)
                        ev = 1'b1;
                    else if (st) begin
                        nhold = rxb;
                        // R9: hold start code until destination known
                        if (ins)
                            nst = E_HOLD;
                        else begin
                            ev = 1'b1;
                            nst = strip ? E_FWD : E_CHK;
                        end
                    end else begin
                        // R10: drop header ahead of a response start code
                        ev = !strip;
                    end
                end
                E_HOLD: if (rxv) begin
                    nstn = rxb;
                    ncnt = 4'h0;
                    nftoo = 1'b0;
                    // R7: own station is executed, not forwarded
                    lv = own;
                    lb = hold_ff;
                    nst = own ? E_LSTN : E_HDR;
                end
                E_HDR: begin
                    ov = rxv;
                    // R8: header bytes go out before the start code
                    if (free[1-s]) begin
                        ev = 1'b1;
                        eb = hdr_ff;
                        ncnt = cnt_ff + 4'h1;
                        // R13: header length by format
                        // R14: binary header length
                        if (cnt_ff == hdr_len(eff) - 4'h1)
                            nst = E_SST;
                    end
                end
                E_SST: begin
                    ov = rxv;
                    if (free[1-s]) begin
                        ev = 1'b1;
                        eb = hold_ff;
                        nst = E_SSTN;
                    end
                end
                E_SSTN: begin
                    ov = rxv;
                    if (free[1-s]) begin
                        ev = 1'b1;
                        eb = stn_ff;
                        nst = E_FWD;
                    end
                end
                E_CHK: if (rxv) begin
                    ev = 1'b1;
                    nstn = rxb;
                    nftoo = 1'b1;
                    // R7: relay also executes its own commands
                    lv = own;
                    lb = hold_ff;
                    nst = own ? E_LSTN : E_FWD;
                end
                E_LSTN: begin
                    ov = rxv;
                    lv = 1'b1;
                    lb = stn_ff;
                    nst = E_LOCAL;
                end
                E_LOCAL: if (rxv) begin
                    lv = 1'b1;
                    ev = ftoo_ff;
                end
                E_FWD: if (rxv)
                    ev = 1'b1;
            endcase
            if (!linked || (tmo && (st_ff == E_FWD || st_ff == E_LOCAL
                    || st_ff == E_CHK || st_ff == E_HOLD)))
                nst = E_IDLE;
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_ff <= E_IDLE;
                hold_ff <= 8'h00;
                stn_ff <= 8'h00;
                cnt_ff <= 4'h0;
                gap_ff <= 12'h000;
                ftoo_ff <= 1'b0;
            end else begin
                st_ff <= nst;
                hold_ff <= nhold;
                stn_ff <= nstn;
                cnt_ff <= ncnt;
                gap_ff <= ngap;
                ftoo_ff <= nftoo;
            end
        end
        assign emit_v[s] = ev;
        assign emit_b[s*8 +: 8] = eb;
        assign loc_v[s] = lv;
        assign loc_b[s*8 +: 8] = lb;
        assign eovr[s] = ov;
        assign enter[s] = nst == E_LSTN && st_ff != E_LSTN;
    end

    // One transmit slot per channel with gate-off spacing
    for (genvar d = 0; d < 2; d++) begin : slot
        logic txv_ff, ntxv;
        logic [7:0] txb_ff, ntxb;
        logic [15:0] g_ff, ng;
        logic so;
        always_comb begin
            ntxv = txv_ff;
            ntxb = txb_ff;
            so = 1'b0;
            ng = (g_ff != 16'h0000) ? g_ff - 16'h0001 : 16'h0000;
            // R15: hold off one character time after each send
            if (txv_ff && tx_ready[d]) begin
                ntxv = 1'b0;
                ng = gate_ff;
            end
            // R21: one character per cycle, in arrival order
            if (emit_v[1-d]) begin
                so = !free[d];
                if (free[d]) begin
                    ntxv = 1'b1;
                    ntxb = emit_b[(1-d)*8 +: 8];
                end
            end else if (rv && rch_ff == 1'(d)) begin
                ntxv = 1'b1;
                ntxb = rbo;
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                txv_ff <= 1'b0;
                txb_ff <= 8'h00;
                g_ff <= 16'h0000;
            end else begin
                txv_ff <= ntxv;
                txb_ff <= ntxb;
                g_ff <= ng;
            end
        end
        assign free[d] = !txv_ff && g_ff == 16'h0000;
        assign sovr[d] = so;
        assign tx_valid[d] = txv_ff;
        assign tx_data[d*8 +: 8] = txb_ff;
    end

    // Local response path
    always_comb begin
        rfree = free[rch_ff] && !emit_v[!rch_ff];
        // R11: header goes out unless the computer itself is the receiver
        rneed = linked && p2 >= 4'h1 && p2 <= `LSCR_P_F5 && !(att && cside == rch_ff);
        nxt_rst = rst_ff;
        nxt_rb = rb_ff;
        nxt_rcnt = rcnt_ff;
        nxt_rrdy = rrdy_ff;
        rv = 1'b0;
        rbo = rb_ff;
        unique case (rst_ff)
            R_IDLE: begin
                nxt_rrdy = 1'b1;
                if (resp_valid && rrdy_ff) begin
                    nxt_rb = resp_data;
                    nxt_rrdy = 1'b0;
                    nxt_rcnt = 4'h0;
                    // R12: header ahead of each response start code
                    nxt_rst = (rneed && is_start(p2, resp_data)) ? R_HDR : R_BYTE;
                end
            end
            R_HDR: if (rfree) begin
                rv = 1'b1;
                rbo = hdr_ff;
                nxt_rcnt = rcnt_ff + 4'h1;
                if (rcnt_ff == hdr_len(p2) - 4'h1)
                    nxt_rst = R_BYTE;
            end
            R_BYTE: if (rfree) begin
                rv = 1'b1;
                nxt_rst = R_IDLE;
                nxt_rrdy = 1'b1;
            end
        endcase
    end

    // Register file, status, interrupts, executor and auto-refresh
    always_comb begin
        hit = 1'b1;
        unique case (paddr)
            `LSCR_CFG_OFF: rd_w = cfg_ff;
            `LSCR_HDR_OFF: rd_w = {24'h000000, hdr_ff};
            `LSCR_GATE_OFF: rd_w = {16'h0000, gate_ff};
            `LSCR_STAT_OFF: rd_w = stat_w;
            default: begin
                rd_w = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
        nxt_pready = psel && !penable;
        nxt_prdata = nxt_pready ? rd_w : prdata_ff;
        nxt_pslverr = nxt_pready && !hit;
        nxt_cfg = cfg_ff;
        nxt_hdr = hdr_ff;
        nxt_gate = gate_ff;
        nxt_ovr = ovr_ff;
        if (psel && penable && pready_ff && pwrite && hit) begin
            if (paddr == `LSCR_CFG_OFF)
                nxt_cfg = pwdata;
            if (paddr == `LSCR_HDR_OFF)
                nxt_hdr = pwdata[7:0];
            if (paddr == `LSCR_GATE_OFF)
                nxt_gate = pwdata[15:0];
            if (paddr == `LSCR_STAT_OFF)
                nxt_ovr = ovr_ff & ~pwdata[`LSCR_OVR_LSB +: 2];
        end
        // New overruns win over a clear in the same cycle
        nxt_ovr = nxt_ovr | eovr | sovr | {1'b0, &loc_v};
        nxt_rch = enter[0] ? 1'b0 : (enter[1] ? 1'b1 : rch_ff);
        nxt_last = last_ff;
        for (int i = 0; i < 2; i++) begin
            if (rx_valid[i])
                nxt_last[i*8 +: 8] = rx_data[i*8 +: 8];
            // R16: reception interrupt for non-procedure or bidirectional
            // R17: one interrupt line per channel
            nxt_irq[i] = rx_valid[i] && (((linked || i == 1) ? p2 : p1) == `LSCR_P_NP
                || ((linked || i == 1) ? p2 : p1) == `LSCR_P_BI);
        end
        nxt_cmdv = |loc_v;
        nxt_cmdd = loc_v[0] ? loc_b[7:0] : loc_b[15:8];
        // R19: push status to host storage whenever it changes
        nxt_arefv = cfg_ff[`LSCR_AREF_BIT] && stat_w != arefd_ff;
        nxt_arefd = nxt_arefv ? stat_w : arefd_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= `LSCR_CFG_RST;
            hdr_ff <= `LSCR_HDR_RST;
            gate_ff <= `LSCR_GATE_RST;
            ovr_ff <= 2'h0;
            rch_ff <= 1'b0;
            last_ff <= 16'h0000;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 2'h0;
            cmdv_ff <= 1'b0;
            cmdd_ff <= 8'h00;
            arefv_ff <= 1'b0;
            arefd_ff <= 32'h0000_0000;
            rst_ff <= R_IDLE;
            rb_ff <= 8'h00;
            rcnt_ff <= 4'h0;
            rrdy_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            hdr_ff <= nxt_hdr;
            gate_ff <= nxt_gate;
            ovr_ff <= nxt_ovr;
            rch_ff <= nxt_rch;
            last_ff <= nxt_last;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
            cmdv_ff <= nxt_cmdv;
            cmdd_ff <= nxt_cmdd;
            arefv_ff <= nxt_arefv;
            arefd_ff <= nxt_arefd;
            rst_ff <= nxt_rst;
            rb_ff <= nxt_rb;
            rcnt_ff <= nxt_rcnt;
            rrdy_ff <= nxt_rrdy;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign rx_irq = irq_ff;
    assign cmd_valid = cmdv_ff;
    assign cmd_data = cmdd_ff;
    assign resp_ready = rrdy_ff;
    assign aref_valid = arefv_ff;
    assign aref_data = arefd_ff;

    AST_FWD_NP: assert property (@(posedge pclk) disable iff (!presetn) // R5
        linked && p2 == `LSCR_P_NP && rx_valid[0] && free[1]
        |=> tx_valid[1] && tx_data[15:8] == $past(rx0_b))
        else $error("character not repeated");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // R17
        rx_valid[1] && p2 == `LSCR_P_NP |=> rx_irq[1])
        else $error("missing receive interrupt");
    AST_NO_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // R16
        !rx_valid[0] |=> !rx_irq[0])
        else $error("spurious receive interrupt");
    AST_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R15
        tx_valid[1] && tx_ready[1] && gate_ff > 16'h0001 |=> !tx_valid[1] [*2])
        else $error("gate-off time violated");
    AST_STRIP: assert property (@(posedge pclk) disable iff (!presetn) // R10
        eng[1].st_ff == E_IDLE && eng[1].strip && linked && rx_valid[1]
        && !eng[1].st && !tx_valid[0] && !(rv && !rch_ff) |=> !tx_valid[0])
        else $error("header not stripped");
    AST_HDR_BYTE: assert property (@(posedge pclk) disable iff (!presetn) // R8
        eng[0].st_ff == E_HDR && free[1] |=> tx_valid[1] && tx_data[15:8] == hdr_ff)
        else $error("header byte wrong");
    AST_LOCAL: assert property (@(posedge pclk) disable iff (!presetn) // R7
        eng[0].st_ff == E_HOLD && rx_valid[0] && eng[0].own
        |=> cmd_valid && cmd_data == $past(eng[0].hold_ff) ##1 cmd_valid)
        else $error("own command not delivered");
    AST_RESP_HDR: assert property (@(posedge pclk) disable iff (!presetn) // R12
        rst_ff == R_IDLE && resp_valid && resp_ready && rneed && is_start(p2, resp_data)
        |=> rst_ff == R_HDR && !resp_ready)
        else $error("response header skipped");
endmodule

// [lscr_chan_model.sv]
// Purpose: Far-side model of both channel UARTs for the linked repeater
// Assumes: Byte lanes, lane 0 is first_channel
// Notes: Slow answering is asked for per lane through stall
module lscr_chan_model (
    // Clock
    input wire logic pclk,
    // Slow answer request per lane
    input wire logic [1:0] stall,
    // Channel streams
    output logic [1:0] rx_valid,
    output logic [15:0] rx_data,
    input wire logic [1:0] tx_valid,
    input wire logic [15:0] tx_data,
    output logic [1:0] tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q0[$];
    logic [7:0] q1[$];
    initial begin
        rx_valid = '0;
        rx_data = '0;
    end
    assign tx_ready = ~stall;
    always @(posedge pclk) begin
        if (tx_valid[0] === 1'b1 && tx_ready[0]) q0.push_back(tx_data[7:0]);
        if (tx_valid[1] === 1'b1 && tx_ready[1]) q1.push_back(tx_data[15:8]);
    end
    // one whole character per call; data line scrambled when idle
    task automatic send(input int l, input logic [7:0] b);
        @(posedge pclk);
        rx_valid[l] <= 1'b1;
        rx_data[8*l +: 8] <= b;
        @(posedge pclk);
        rx_valid[l] <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the linked repeater
// Assumes: Message gap GAP_CYC shortened to 200
// Notes: Character spacing kept below the message gap
`include "lscr_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, cmd_valid, resp_ready, aref_valid;
    logic [1:0] rx_valid, tx_valid, tx_ready, rx_irq;
    logic [1:0] stall = '0;
    logic [15:0] rx_data, tx_data;
    logic [7:0] cmd_data;
    logic resp_valid = 0;
    logic [7:0] resp_data = '0;
    logic [31:0] aref_data, rd;
    logic er;
    int err_total, n_tests, aref_n;
    int irq_n[2];
    logic [7:0] cmdq[$];
    logic [7:0] e[$];
    logic [7:0] st[3] = '{`LSCR_ENQ, `LSCR_ENQ, `LSCR_DLE};
    int code[3] = '{1, 2, 5};
    int hl[3] = '{13, 15, 10};
    always #5 pclk = ~pclk;
    lscr_repeater #(.GAP_CYC(200)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_irq(rx_irq),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_ready(resp_ready), .aref_valid(aref_valid),
        .aref_data(aref_data));
    lscr_chan_model u_far (.pclk(pclk), .stall(stall), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    always @(posedge pclk) begin
        if (rx_irq[0] === 1'b1) irq_n[0]++;
        if (rx_irq[1] === 1'b1) irq_n[1]++;
        if (cmd_valid === 1'b1) cmdq.push_back(cmd_data);
        if (aref_valid === 1'b1) aref_n++;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        n_tests++;
        if (got !== ex) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chkq(input int l, input logic [7:0] ex[$]);
        logic [7:0] g[$];
        if (l == 1) g = u_far.q1;
        else g = u_far.q0;
        chk("tx count", 32'(g.size()), 32'(ex.size()));
        foreach (ex[i]) begin
            if (i < g.size()) chk("tx byte", {24'h0, g[i]}, {24'h0, ex[i]});
        end
    endtask
    task automatic sendw(input int l, input logic [7:0] b, input int w);
        u_far.send(l, b);
        repeat (w) @(posedge pclk);
    endtask
    task automatic clr();
        u_far.q0.delete();
        u_far.q1.delete();
        cmdq.delete();
        e.delete();
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(0, 12'(a), 0);
            chk("reset value", rd, 0);
        end
        apb(0, 12'h010, 0);
        chk("unmapped error", {31'h0, er}, 1);
        apb(1, `LSCR_GATE_OFF, 32'h1234);
        apb(0, `LSCR_GATE_OFF, 0);
        chk("gate rw", rd, 32'h1234);
        apb(1, `LSCR_GATE_OFF, 0);
        $display("test registers done");
        apb(1, `LSCR_CFG_OFF, 32'h0000_1608);
        apb(0, `LSCR_STAT_OFF, 0);
        chk("linked flag", {31'h0, rd[0]}, 1);
        sendw(0, 8'h41, 10);
        sendw(0, 8'h42, 10);
        sendw(1, 8'h43, 20);
        e = '{8'h41, 8'h42};
        chkq(1, e);
        e = '{8'h43};
        chkq(0, e);
        chk("irq first", 32'(irq_n[0]), 2);
        chk("irq second", 32'(irq_n[1]), 1);
        clr();
        stall <= 2'b10;
        sendw(0, 8'h51, 5);
        sendw(0, 8'h52, 5);
        apb(0, `LSCR_STAT_OFF, 0);
        chk("overrun", {31'h0, |rd[2:1]}, 1);
        stall <= 2'b00;
        repeat (20) @(posedge pclk);
        apb(1, `LSCR_STAT_OFF, 32'h6);
        apb(0, `LSCR_STAT_OFF, 0);
        chk("overrun clear", {30'h0, rd[2:1]}, 0);
        e = '{8'h51};
        chkq(1, e);
        clr();
        apb(1, `LSCR_GATE_OFF, 32'h10);
        sendw(0, 8'h61, 3);
        sendw(0, 8'h62, 30);
        sendw(0, 8'h63, 30);
        apb(0, `LSCR_STAT_OFF, 0);
        chk("gate overrun", {31'h0, rd[2]}, 1);
        apb(1, `LSCR_STAT_OFF, 32'h6);
        apb(1, `LSCR_GATE_OFF, 0);
        e = '{8'h61, 8'h63};
        chkq(1, e);
        $display("test repeat done");
        apb(1, `LSCR_HDR_OFF, 32'ha5);
        for (int k = 0; k < 3; k++) begin
            clr();
            apb(1, `LSCR_CFG_OFF, 32'h0103_1008 | (32'(code[k]) << 8));
            sendw(0, st[k], 60);
            sendw(0, 8'h07, 60);
            sendw(0, 8'h78, 400);
            repeat (hl[k]) e.push_back(8'ha5);
            e.push_back(st[k]);
            e.push_back(8'h07);
            e.push_back(8'h78);
            chkq(1, e);
            clr();
            sendw(0, st[k], 60);
            sendw(0, 8'h03, 60);
            sendw(0, 8'h78, 400);
            chk("local count", 32'(cmdq.size()), 3);
            if (cmdq.size() == 3) chk("local start", {24'h0, cmdq[0]}, {24'h0, st[k]});
            chkq(1, e);
        end
        clr();
        apb(1, `LSCR_CFG_OFF, 32'h0103_1108);
        sendw(1, 8'h99, 60);
        sendw(1, `LSCR_ACK, 60);
        sendw(1, 8'h55, 400);
        e = '{`LSCR_ACK, 8'h55};
        chkq(0, e);
        $display("test header done");
        clr();
        apb(1, `LSCR_CFG_OFF, 32'h0403_1108);
        sendw(1, `LSCR_ENQ, 60);
        sendw(1, 8'h03, 400);
        e = '{`LSCR_ENQ, 8'h03};
        chkq(0, e);
        chk("relay local", 32'(cmdq.size()), 2);
        @(posedge pclk);
        resp_valid <= 1'b1;
        resp_data <= `LSCR_ACK;
        do @(posedge pclk);
        while (resp_ready !== 1'b1);
        resp_valid <= 1'b0;
        resp_data <= ~resp_data;
        repeat (100) @(posedge pclk);
        e.delete();
        repeat (13) e.push_back(8'ha5);
        e.push_back(`LSCR_ACK);
        chkq(1, e);
        chk("refresh seen", {31'h0, aref_n != 0}, 1);
        chk("refresh data", aref_data, 32'h0003_7809);
        $display("test response done");
        end_sim();
    end
endmodule
